// ### rtl/fdp_map.svh
/*
 holds the register indices, field positions, reset values and clock
 figures of the fan drive block. assumes inclusion by bare name.
*/
`ifndef FDP_MAP_SVH
`define FDP_MAP_SVH
`define FDP_IDX_FREQ 7'h02
`define FDP_IDX_VALUE 7'h03
`define FDP_IDX_CONFIG 7'h04
`define FDP_RST_FREQ 8'h04
`define FDP_RST_VALUE 8'hff
`define FDP_RST_CONFIG 8'h01
`define FDP_CFG_MASK 8'h3f
`define FDP_FREQ_SRC_BIT 7
`define FDP_CFG_CPU_ANALOG_BIT 1
`define FDP_CFG_SYS_ANALOG_BIT 0
`define FDP_DUTY_FULL 8'hff
`define FDP_RST_INDEX 7'h00
`define FDP_INDEX_MSB 6
`define FDP_PRESCALE_MSB 6
`define FDP_CODE_MSB 7
`define FDP_CODE_LSB 2
`define FDP_CPU_MODE_LSB 4
`define FDP_SYS_MODE_LSB 2
`define FDP_READ_NONE 8'h00
`define FDP_CODE_NONE 6'h00
`define FDP_CORE_HZ 25000000
`define FDP_FAST_HZ 24000000
`define FDP_SLOW_HZ 180000
`endif

// ### rtl/fdp_pkg.sv
/*
 holds the mode types of the fan drive block. assumes nothing.
*/
package fdp_pkg;
   typedef enum logic [1:0]
   {
      FDP_MANUAL = 2'h0,
      FDP_THERMAL = 2'h1,
      FDP_SPEED = 2'h2,
      FDP_PIECEWISE = 2'h3
   } fdp_mode_type;
   typedef enum logic [1:0]
   {
      FDP_S_PWM = 2'b01,
      FDP_S_VOLT = 2'b10
   } fdp_drive_type;
endpackage

// ### rtl/fdp_pwm_channel.sv
/*
 one pwm channel: prescaled tick feeding an 8-bit period counter.
 assumes a tick input already at the selected source rate.
*/
`timescale 1ns/1ps
`include "fdp_map.svh"
module fdp_pwm_channel
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic src_tick,
   input wire logic [6:0] prescale,
   input wire logic [7:0] duty,
   output logic pwm_level
);
   logic [6:0] pre_reg;
   logic [7:0] count_reg;
   logic step;

   // prescaler divides source ticks by the field value
   assign step = src_tick && (pre_reg + 7'h01 >= prescale);
   always_ff @(posedge core_clk)
   begin
      if (rst)
         pre_reg <= 7'h00;
      else if (step)
         pre_reg <= 7'h00;
      else if (src_tick)
         pre_reg <= pre_reg + 7'h01;
   end

   // period counter, 256 steps per period
   always_ff @(posedge core_clk)
   begin
      if (rst)
         count_reg <= 8'h00;
      else if (step)
         count_reg <= count_reg + 8'h01;
   end

   // high while count below duty, full duty constant high
   always_ff @(posedge core_clk)
   begin
      if (rst)
         pwm_level <= 1'b1;
      else
         pwm_level <= (duty == `FDP_DUTY_FULL) || (count_reg < duty);
   end
endmodule

// ### rtl/fdp_fan_drive.sv
/*
 fan drive top: index/data register port, frequency, value and
 configuration registers, one prescaled pwm channel and the voltage
 code path of the processor fan, mode outputs of both fans.
 assumes bus strobes are single core_clk pulses from same-domain logic,
 and that software keeps the prescaler field nonzero.
*/
// Behaviour
// - bit 7 picks 24 MHz or 180 KHz
// - bits 6-0 divide the selected clock
// - pwm frequency is clock over prescale over 256
// - frequency ignored in voltage mode
// - duty FFh high, 00h low
// - other duty gives high fraction value/256
// - config bit 1 picks duty or code
// - voltage code is bits 7-2
// - bits 5-4 processor fan mode
// - bits 3-2 system fan mode, 11 none
// - bit 1 processor pin pwm or analog
// - bit 0 system pin pwm or analog
// - reset values 04h, FFh, 01h
`timescale 1ns/1ps
`include "fdp_map.svh"
module fdp_fan_drive
#(
   parameter int CORE_HZ = `FDP_CORE_HZ
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic addr_wr,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic processor_fan_output,
   output logic [5:0] voltage_code,
   output logic processor_fan_analog,
   output logic system_fan_analog,
   output fdp_pkg::fdp_mode_type processor_fan_mode,
   output fdp_pkg::fdp_mode_type system_fan_mode
);
   // accumulator wide enough for the core rate plus one source rate
   localparam int ACC_W = $clog2(CORE_HZ) + 1;
   localparam int FAST_HZ = `FDP_FAST_HZ;
   localparam int SLOW_HZ = `FDP_SLOW_HZ;
   localparam int SEL_FREQ = 0;
   localparam int SEL_VALUE = 1;
   localparam int SEL_CONFIG = 2;
   localparam logic [7:0] RST_CONFIG = `FDP_RST_CONFIG;

   // registers, decode and source ticks
   logic [6:0] index_reg;
   logic [7:0] freq_reg;
   logic [7:0] value_reg;
   logic [7:0] config_reg;
   logic [2:0] reg_sel;
   logic [ACC_W-1:0] fast_acc_reg;
   logic [ACC_W-1:0] slow_acc_reg;
   logic [ACC_W:0] fast_sum;
   logic [ACC_W:0] slow_sum;
   logic fast_tick_reg;
   logic slow_tick_reg;
   logic src_tick;
   logic pwm_level;
   fdp_pkg::fdp_drive_type drive_reg;
   fdp_pkg::fdp_drive_type drive_next;

   // fractional accumulator: tick at rate hz out of CORE_HZ
   function automatic logic [ACC_W:0] acc_step(input logic [ACC_W-1:0] acc,
                                                input int hz);
      logic [ACC_W:0] sum;
      sum = {1'b0, acc} + (ACC_W+1)'(hz);
      if (sum >= (ACC_W+1)'(CORE_HZ))
         sum = {1'b1, ACC_W'(sum - (ACC_W+1)'(CORE_HZ))};
      else
         sum = {1'b0, sum[ACC_W-1:0]};
      return sum;
   endfunction

   // one-hot select of the register that the latched index names
   function automatic logic [2:0] reg_select(input logic [6:0] idx);
      logic [2:0] sel;
      sel = 3'b000;
      case (idx)
         `FDP_IDX_FREQ:
            sel[SEL_FREQ] = 1'b1;
         `FDP_IDX_VALUE:
            sel[SEL_VALUE] = 1'b1;
         `FDP_IDX_CONFIG:
            sel[SEL_CONFIG] = 1'b1;
         default:
            sel = 3'b000;
      endcase
      return sel;
   endfunction

   // two-bit mode field at a given position of a configuration word
   function automatic fdp_pkg::fdp_mode_type mode_field(input logic [7:0] cfg,
                                                        input int lsb);
      return fdp_pkg::fdp_mode_type'(cfg[lsb +: 2]);
   endfunction

   // index latch; bit 7 of the address port is reserved
   always_ff @(posedge core_clk)
   begin
      if (rst)
         index_reg <= `FDP_RST_INDEX;
      else if (addr_wr)
         index_reg <= wr_data[`FDP_INDEX_MSB:0];
   end

   // decode shared by the write and read paths
   assign reg_sel = reg_select(index_reg);

   // frequency register: source bit and prescaler
   always_ff @(posedge core_clk)
   begin
      if (rst)
         freq_reg <= `FDP_RST_FREQ;
      else if (data_wr && reg_sel[SEL_FREQ])
         freq_reg <= wr_data;
   end

   // output value register: duty or voltage code
   always_ff @(posedge core_clk)
   begin
      if (rst)
         value_reg <= `FDP_RST_VALUE;
      else if (data_wr && reg_sel[SEL_VALUE])
         value_reg <= wr_data;
   end

   // configuration register; reserved bits 7-6 stay zero
   always_ff @(posedge core_clk)
   begin
      if (rst)
         config_reg <= `FDP_RST_CONFIG;
      else if (data_wr && reg_sel[SEL_CONFIG])
         config_reg <= wr_data & `FDP_CFG_MASK;
   end

   // read mux, unmapped indices read zero
   always_ff @(posedge core_clk)
   begin
      if (rst)
         rd_data <= `FDP_READ_NONE;
      else if (data_rd)
      begin
         if (reg_sel[SEL_FREQ])
            rd_data <= freq_reg;
         else if (reg_sel[SEL_VALUE])
            rd_data <= value_reg;
         else if (reg_sel[SEL_CONFIG])
            rd_data <= config_reg;
         else
            rd_data <= `FDP_READ_NONE;
      end
   end

   // next accumulator values; the carry bit is the tick
   assign fast_sum = acc_step(fast_acc_reg, FAST_HZ);
   assign slow_sum = acc_step(slow_acc_reg, SLOW_HZ);

   // 24 MHz tick; dropped core ticks leave some period jitter
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         fast_acc_reg <= '0;
         fast_tick_reg <= 1'b0;
      end
      else
      begin
         fast_acc_reg <= fast_sum[ACC_W-1:0];
         fast_tick_reg <= fast_sum[ACC_W];
      end
   end

   // 180 KHz tick, one core cycle wide
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         slow_acc_reg <= '0;
         slow_tick_reg <= 1'b0;
      end
      else
      begin
         slow_acc_reg <= slow_sum[ACC_W-1:0];
         slow_tick_reg <= slow_sum[ACC_W];
      end
   end

   // source select by frequency bit 7
   assign src_tick = freq_reg[`FDP_FREQ_SRC_BIT] ? slow_tick_reg : fast_tick_reg;

   // prescaled 256-step channel
   fdp_pwm_channel u_channel
   (
      .core_clk(core_clk),
      .rst(rst),
      .src_tick(src_tick),
      .prescale(freq_reg[`FDP_PRESCALE_MSB:0]),
      .duty(value_reg),
      .pwm_level(pwm_level)
   );

   // next drive state follows config bit 1
   always_comb
   begin
      drive_next = drive_reg;
      case (drive_reg)
         fdp_pkg::FDP_S_PWM:
            if (config_reg[`FDP_CFG_CPU_ANALOG_BIT])
               drive_next = fdp_pkg::FDP_S_VOLT;
         fdp_pkg::FDP_S_VOLT:
            if (!config_reg[`FDP_CFG_CPU_ANALOG_BIT])
               drive_next = fdp_pkg::FDP_S_PWM;
         default:
            drive_next = fdp_pkg::FDP_S_PWM;
      endcase
   end

   // drive state register, pwm after reset
   always_ff @(posedge core_clk)
   begin
      if (rst)
         drive_reg <= fdp_pkg::FDP_S_PWM;
      else
         drive_reg <= drive_next;
   end

   // pin level per drive state; frequency unused in voltage mode
   always_ff @(posedge core_clk)
   begin
      if (rst)
         processor_fan_output <= 1'b1;
      else
      begin
         case (drive_reg)
            fdp_pkg::FDP_S_PWM:
               processor_fan_output <= pwm_level;
            fdp_pkg::FDP_S_VOLT:
               processor_fan_output <= 1'b0;
            default:
               processor_fan_output <= 1'b0;
         endcase
      end
   end

   // voltage code per drive state; reserved value bits 1-0 dropped
   always_ff @(posedge core_clk)
   begin
      if (rst)
         voltage_code <= `FDP_CODE_NONE;
      else
      begin
         case (drive_reg)
            fdp_pkg::FDP_S_PWM:
               voltage_code <= `FDP_CODE_NONE;
            fdp_pkg::FDP_S_VOLT:
               voltage_code <= value_reg[`FDP_CODE_MSB:`FDP_CODE_LSB];
            default:
               voltage_code <= `FDP_CODE_NONE;
         endcase
      end
   end

   // processor fan mode from config bits 5-4
   always_ff @(posedge core_clk)
   begin
      if (rst)
         processor_fan_mode <= mode_field(RST_CONFIG, `FDP_CPU_MODE_LSB);
      else
         processor_fan_mode <= mode_field(config_reg, `FDP_CPU_MODE_LSB);
   end

   // system fan mode; code 11 passes on with no function
   always_ff @(posedge core_clk)
   begin
      if (rst)
         system_fan_mode <= mode_field(RST_CONFIG, `FDP_SYS_MODE_LSB);
      else
         system_fan_mode <= mode_field(config_reg, `FDP_SYS_MODE_LSB);
   end

   // processor pin kind from config bit 1
   always_ff @(posedge core_clk)
   begin
      if (rst)
         processor_fan_analog <= RST_CONFIG[`FDP_CFG_CPU_ANALOG_BIT];
      else
         processor_fan_analog <= config_reg[`FDP_CFG_CPU_ANALOG_BIT];
   end

   // system pin kind from config bit 0
   always_ff @(posedge core_clk)
   begin
      if (rst)
         system_fan_analog <= RST_CONFIG[`FDP_CFG_SYS_ANALOG_BIT];
      else
         system_fan_analog <= config_reg[`FDP_CFG_SYS_ANALOG_BIT];
   end
endmodule

// ### sim/fdp_fan_model.sv
/*
 fan model: tallies high cycles and rising edges of the pwm pin.
 assumes pin, gate and clear all sampled on core_clk.
*/
`timescale 1ns/1ps
module fdp_fan_model
(
   input wire logic core_clk,
   input wire logic gate,
   input wire logic clr,
   input wire logic pwm_in,
   output logic [15:0] hi_count,
   output logic [7:0] rise_count
);
   logic last_reg;
   // counts only while the gate is open
   always_ff @(posedge core_clk)
   begin
      last_reg <= pwm_in;
      hi_count <= clr ? 16'h0000 : hi_count + 16'(gate && pwm_in);
      rise_count <= clr ? 8'h00 : rise_count + 8'(gate && pwm_in && !last_reg);
   end
endmodule

// ### sim/fdp_fan_drive_assertions.sv
/*
 checker: port relations of the fan drive top.
 assumes bind into fdp_fan_drive, one clock domain.
*/
`timescale 1ns/1ps
module fdp_fan_drive_assertions
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [7:0] rd_data,
   input wire logic processor_fan_output,
   input wire logic [5:0] voltage_code,
   input wire logic processor_fan_analog,
   input wire logic system_fan_analog,
   input wire fdp_pkg::fdp_mode_type processor_fan_mode,
   input wire fdp_pkg::fdp_mode_type system_fan_mode
);
   logic [1:0] up_reg;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // cycles since reset release, saturating
   always_ff @(posedge core_clk)
   begin
      up_reg <= rst ? 2'h0 : (up_reg == 2'h3 ? up_reg : up_reg + 2'h1);
   end
   reset_values_a: assert property ($fell(rst) |-> rd_data == 8'h00
      && processor_fan_output && voltage_code == 6'h00 && !processor_fan_analog
      && system_fan_analog && processor_fan_mode == 2'h0 && system_fan_mode == 2'h0)
      else $error("reset values wrong");
   volt_pin_low_a: assert property (processor_fan_analog && $past(processor_fan_analog)
      |-> !processor_fan_output) else $error("pin driven in voltage mode");
   pwm_code_zero_a: assert property (!processor_fan_analog && !$past(processor_fan_analog)
      |-> voltage_code == 6'h00) else $error("code present in pwm mode");
   read_hold_a: assert property (up_reg == 2'h3 && $changed(rd_data) |-> $past(data_rd))
      else $error("read data moved without read");
   cpu_mode_src_a: assert property (up_reg == 2'h3 && $changed(processor_fan_mode)
      |-> $past(data_wr, 2)) else $error("cpu mode moved without write");
   sys_mode_src_a: assert property (up_reg == 2'h3 && $changed(system_fan_mode)
      |-> $past(data_wr, 2)) else $error("sys mode moved without write");
   analog_src_a: assert property (up_reg == 2'h3 && ($changed(processor_fan_analog)
      || $changed(system_fan_analog)) |-> $past(data_wr, 2)) else $error("drive kind moved");
   code_src_a: assert property (up_reg == 2'h3 && $changed(voltage_code)
      |-> $past(data_wr, 2) || $past(data_wr, 3)) else $error("code moved without write");
endmodule
bind fdp_fan_drive fdp_fan_drive_assertions chk_u (.core_clk(core_clk), .rst(rst),
   .data_wr(data_wr), .data_rd(data_rd), .rd_data(rd_data),
   .processor_fan_output(processor_fan_output), .voltage_code(voltage_code),
   .processor_fan_analog(processor_fan_analog), .system_fan_analog(system_fan_analog),
   .processor_fan_mode(processor_fan_mode), .system_fan_mode(system_fan_mode));

// ### sim/tb_top.sv
/*
 testbench: index/data register tests and pwm measurement.
 assumes the fan model and checker compiled before.
*/
`timescale 1ns/1ps
module tb_top;
   logic core_clk, rst, addr_wr, data_wr, data_rd, gate, clr;
   logic [7:0] wr_data, rd_data, rise_count;
   logic processor_fan_output, processor_fan_analog, system_fan_analog;
   logic [5:0] voltage_code;
   logic [15:0] hi_count;
   fdp_pkg::fdp_mode_type processor_fan_mode, system_fan_mode;
   int bad_count, num_checks;
   fdp_fan_drive dut_u (.core_clk(core_clk), .rst(rst), .addr_wr(addr_wr),
      .data_wr(data_wr), .data_rd(data_rd), .wr_data(wr_data), .rd_data(rd_data),
      .processor_fan_output(processor_fan_output), .voltage_code(voltage_code),
      .processor_fan_analog(processor_fan_analog), .system_fan_analog(system_fan_analog),
      .processor_fan_mode(processor_fan_mode), .system_fan_mode(system_fan_mode));
   fdp_fan_model fan_u (.core_clk(core_clk), .gate(gate), .clr(clr),
      .pwm_in(processor_fan_output), .hi_count(hi_count), .rise_count(rise_count));
   // 25 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // index then data, one strobe each
   task wr(input logic [7:0] idx, input logic [7:0] v);
      @(posedge core_clk) {addr_wr, wr_data} <= {1'b1, idx};
      @(posedge core_clk) {addr_wr, data_wr, wr_data} <= {2'b01, v};
      @(posedge core_clk) data_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] idx, input logic [7:0] exp);
      @(posedge core_clk) {addr_wr, wr_data} <= {1'b1, idx};
      @(posedge core_clk) {addr_wr, data_rd} <= 2'b01;
      @(posedge core_clk) data_rd <= 1'b0;
      step(1);
      chk("rd_data", rd_data, exp);
   endtask
   // high cycles within tol, rising edges within one
   task meas(input int hi, input int tol, input int rises);
      @(posedge core_clk) clr <= 1'b1;
      @(posedge core_clk) {clr, gate} <= 2'b01;
      repeat (1600) @(posedge core_clk);
      gate <= 1'b0;
      step(1);
      chk("high", hi_count + tol >= hi && hi_count <= hi + tol, 1);
      chk("rises", rise_count + 1 >= rises && rise_count <= rises + 1, 1);
   endtask
   initial
   begin
      {rst, addr_wr, data_wr, data_rd, gate, clr, wr_data} = {6'h21, 8'h00};
      {bad_count, num_checks} = 0;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      rd(8'h02, 8'h04);
      rd(8'h03, 8'hff);
      rd(8'h04, 8'h01);
      chk("pin", processor_fan_output, 1);
      chk("sys_analog", system_fan_analog, 1);
      $display("test reset done");
      for (int m = 0; m < 4; m++)
      begin
         wr(8'h04, 8'(m * 20));
         step(2);
         chk("cpu_mode", processor_fan_mode, m);
         chk("sys_mode", system_fan_mode, m);
      end
      wr(8'h04, 8'hff);
      rd(8'h04, 8'h3f);
      wr(8'h05, 8'h5a);
      rd(8'h05, 8'h00);
      $display("test modes done");
      wr(8'h04, 8'h00);
      wr(8'h02, 8'h01);
      wr(8'h03, 8'h40);
      step(600);
      meas(400, 12, 6);
      wr(8'h03, 8'h00);
      step(600);
      meas(0, 0, 0);
      wr(8'h02, 8'h02);
      wr(8'h03, 8'hc0);
      step(1200);
      meas(1200, 12, 3);
      wr(8'h02, 8'h81);
      wr(8'h03, 8'h01);
      meas(70, 70, 0);
      $display("test pwm done");
      wr(8'h03, 8'ha7);
      wr(8'h04, 8'h02);
      wr(8'h02, 8'h05);
      step(3);
      chk("code", voltage_code, 6'h29);
      chk("pin", processor_fan_output, 0);
      chk("cpu_analog", processor_fan_analog, 1);
      chk("sys_analog", system_fan_analog, 0);
      $display("test voltage done");
      @(posedge core_clk) rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rd(8'h02, 8'h04);
      rd(8'h03, 8'hff);
      rd(8'h04, 8'h01);
      chk("code", voltage_code, 6'h00);
      chk("pin", processor_fan_output, 1);
      chk("cpu_analog", processor_fan_analog, 0);
      $display("test reset again done");
      end_of_test;
   end
endmodule
